/* hdl/vcc_comparator_control.sv */
// control, event flags and routing around the uncommitted voltage comparator
//
// What this block does
// - One 16-bit control and status register serves the comparator, bits 15 to 11 reserved.
// - Bit 10 switches the comparator on when set and off when cleared.
// - Bits 9:8 pick the negative input: 01 converter channel three, 10 first DAC output.
// - The positive input is multiplexed onto the converter channel two pin.
// - Bits 7:6 route the output: 00 converter start, 10 output pin, 11 interrupt.
// - Bit 5 inverts the output so it is high while the positive input is the lower.
// - Bits 4:3 pick a response time of 10, 5, 1 or 0.5 us and bit 2 turns on hysteresis.
// - Bit 1 is set by a rising edge of the compare result and cleared by writing one.
// - Bit 0 is set by a falling edge of the compare result and cleared by software.
// - The compare result always goes straight to the programmable logic array too.
`timescale 1ns/1ps
module vcc_comparator_control (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [vcc_pkg::VCC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [vcc_pkg::VCC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [vcc_pkg::VCC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [vcc_pkg::VCC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // analog comparator decision, high while positive exceeds negative
  input wire logic compare_raw,
  // analog controls
  output logic comparator_on,
  output logic positive_input_connect,
  output logic negative_select_channel_three,
  output logic negative_select_first_dac,
  output logic [1:0] response_time_select,
  output logic hysteresis_on,
  // result destinations
  output logic comparator_pla_out,
  output logic comparator_output_pin,
  output logic converter_start,
  output logic irq
);
  import vcc_pkg::*;

  typedef struct packed {
    logic [VCC_REG_W-1:0] ctrl;
    logic [VCC_FLAG_W-1:0] mask;
    logic aw_full;
    logic [VCC_ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [VCC_REG_W-1:0] w_data;
    logic [1:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [VCC_DATA_W-1:0] r_data;
    logic [1:0] r_resp;
    logic prev;
    logic start;
    logic pin;
  } vcc_state_s;

  vcc_state_s s_q;
  vcc_state_s s_d;

  // unused protection bits and upper byte lanes
  logic unused_inputs;
  assign unused_inputs = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16], s_axi_wstrb[3:2]};

  // decoded control fields
  logic ctl_on;
  logic [1:0] ctl_neg;
  vcc_route_e ctl_route;
  logic ctl_pol;
  logic [1:0] ctl_resp;
  logic neg_valid;

  assign ctl_on = s_q.ctrl[VCC_ON_BIT];
  assign ctl_neg = s_q.ctrl[VCC_NEG_LO +: 2];
  assign ctl_route = vcc_route_e'(s_q.ctrl[VCC_ROUTE_LO +: 2]);
  assign ctl_pol = s_q.ctrl[VCC_POL_BIT];
  assign ctl_resp = s_q.ctrl[VCC_RESP_LO +: 2];
  // reserved negative codes leave the minus side floating, so no decision
  assign neg_valid = (ctl_neg == VCC_NEG_CH3) || (ctl_neg == VCC_NEG_DAC);

  // decision after enable and polarity, then settled over the response time
  logic live;
  logic settled;
  logic rise;
  logic fall;

  assign live = ctl_on && neg_valid && (compare_raw ^ ctl_pol);

  vcc_response_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(live),
    .time_sel(ctl_resp),
    .settled_q(settled)
  );

  // edges of the monitored result
  assign rise = settled && !s_q.prev;
  assign fall = !settled && s_q.prev;

  // 16-bit lane mask from the two low write strobes
  function automatic logic [VCC_REG_W-1:0] vcc_lanes(input logic [1:0] strb);
    vcc_lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : vcc_lanes

  // read word for an address, zero above the register width
  function automatic logic [VCC_DATA_W-1:0] vcc_read(
    input logic [VCC_ADDR_W-1:0] addr,
    input logic [VCC_REG_W-1:0] ctrl,
    input logic [VCC_FLAG_W-1:0] mask
  );
    vcc_read = '0;
    if (addr == VCC_CTRL_ADDR) begin
      vcc_read[VCC_REG_W-1:0] = ctrl;
    end else if (addr == VCC_MASK_ADDR) begin
      vcc_read[VCC_FLAG_W-1:0] = mask;
    end
  endfunction : vcc_read

  // address decode, shared by both channels
  function automatic logic vcc_hit(input logic [VCC_ADDR_W-1:0] addr);
    vcc_hit = (addr == VCC_CTRL_ADDR) || (addr == VCC_MASK_ADDR);
  endfunction : vcc_hit

  // a write commits once address and data are both held
  logic commit;
  logic ctrl_wr;
  logic [VCC_REG_W-1:0] lane_mask;
  logic [VCC_REG_W-1:0] cfg_mask;
  logic [VCC_FLAG_W-1:0] flag_clr;

  assign commit = s_q.aw_full && s_q.w_full && !s_q.b_valid;
  assign ctrl_wr = commit && (s_q.aw_addr == VCC_CTRL_ADDR);
  assign lane_mask = vcc_lanes(s_q.w_strb);
  // flags and reserved bits are never stored from the bus
  assign cfg_mask = lane_mask & VCC_CTRL_WMASK;
  // only ones clear; a zero leaves the flag alone
  assign flag_clr = ctrl_wr ? (s_q.w_data[VCC_FLAG_W-1:0] & lane_mask[VCC_FLAG_W-1:0])
                            : '0;

  // handshake readies: one write and one read in flight at a time
  assign s_axi_awready = !s_q.aw_full && !s_q.b_valid;
  assign s_axi_wready = !s_q.w_full && !s_q.b_valid;
  assign s_axi_arready = !s_q.r_valid;

  // next state of bus slave, register and routing
  always_comb begin
    s_d = s_q;
    s_d.prev = settled;

    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata[VCC_REG_W-1:0];
      s_d.w_strb = s_axi_wstrb[1:0];
    end

    // commit: configuration bits by lane, mask register, response
    if (commit) begin
      if (ctrl_wr) begin
        s_d.ctrl = (s_q.ctrl & ~cfg_mask) | (s_q.w_data & cfg_mask);
      end
      if (s_q.aw_addr == VCC_MASK_ADDR) begin
        s_d.mask = (s_q.mask & ~lane_mask[VCC_FLAG_W-1:0])
                 | (s_q.w_data[VCC_FLAG_W-1:0] & lane_mask[VCC_FLAG_W-1:0]);
      end
      s_d.b_resp = vcc_hit(s_q.aw_addr) ? VCC_RESP_OKAY : VCC_RESP_SLVERR;
      s_d.b_valid = 1'b1;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
    end else if (s_q.b_valid && s_axi_bready) begin
      s_d.b_valid = 1'b0;
    end

    // sticky edge flags: a set in the clearing cycle wins
    s_d.ctrl[VCC_RISE_BIT] = (s_q.ctrl[VCC_RISE_BIT] & ~flag_clr[VCC_RISE_BIT]) | rise;
    s_d.ctrl[VCC_FALL_BIT] = (s_q.ctrl[VCC_FALL_BIT] & ~flag_clr[VCC_FALL_BIT]) | fall;

    // read channel: data registered, answered the edge after the address
    if (s_q.r_valid && s_axi_rready) begin
      s_d.r_valid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.r_valid = 1'b1;
      s_d.r_data = vcc_read(s_axi_araddr, s_q.ctrl, s_q.mask);
      s_d.r_resp = vcc_hit(s_axi_araddr) ? VCC_RESP_OKAY : VCC_RESP_SLVERR;
    end

    // destinations; the reserved route code drives nothing
    s_d.start = 1'b0;
    s_d.pin = 1'b0;
    unique case (ctl_route)
      VCC_ROUTE_ADC: s_d.start = rise;
      VCC_ROUTE_PIN: s_d.pin = settled;
      VCC_ROUTE_IRQ: s_d.start = 1'b0;
      VCC_ROUTE_RSVD: s_d.start = 1'b0;
    endcase
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= VCC_CTRL_RST;
      s_q.mask <= VCC_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // bus answers
  assign s_axi_bvalid = s_q.b_valid;
  assign s_axi_bresp = s_q.b_resp;
  assign s_axi_rvalid = s_q.r_valid;
  assign s_axi_rdata = s_q.r_data;
  assign s_axi_rresp = s_q.r_resp;

  // analog controls straight from the register
  assign comparator_on = ctl_on;
  assign positive_input_connect = ctl_on;
  assign negative_select_channel_three = ctl_on && (ctl_neg == VCC_NEG_CH3);
  assign negative_select_first_dac = ctl_on && (ctl_neg == VCC_NEG_DAC);
  assign response_time_select = ctl_resp;
  assign hysteresis_on = s_q.ctrl[VCC_HYST_BIT];

  // the logic array sees the result whatever the route
  assign comparator_pla_out = settled;
  assign comparator_output_pin = s_q.pin;
  assign converter_start = s_q.start;
  // level interrupt only while routed to the interrupt and unmasked
  assign irq = (ctl_route == VCC_ROUTE_IRQ)
            && |(s_q.ctrl[VCC_FLAG_W-1:0] & s_q.mask);

  // reserved bits always read as zero
  property p_resv_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[VCC_DATA_W-1:VCC_RESV_LO] == '0);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved read bits not zero");

  // the enable bit follows a write to its lane one edge later
  property p_enable_write;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_wr && s_q.w_strb[1]) |=> (comparator_on == $past(s_q.w_data[VCC_ON_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow write");

  // reserved negative codes select nothing
  property p_neg_reserved;
    @(posedge aclk) disable iff (!aresetn)
      !neg_valid |-> !negative_select_channel_three && !negative_select_first_dac && !live;
  endproperty
  a_neg_reserved: assert property (p_neg_reserved)
    else $error("reserved negative code connected an input");

  // rising edge sets the flag by the next edge
  property p_rise_flag;
    @(posedge aclk) disable iff (!aresetn)
      rise |=> s_q.ctrl[VCC_RISE_BIT];
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rising flag not set");

  // falling edge sets the flag by the next edge
  property p_fall_flag;
    @(posedge aclk) disable iff (!aresetn)
      fall |=> s_q.ctrl[VCC_FALL_BIT];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling flag not set");

  // the rising flag only drops after a one was written to it
  property p_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
      $fell(s_q.ctrl[VCC_RISE_BIT]) |-> $past(flag_clr[VCC_RISE_BIT]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("rising flag cleared without a one written");

  // converter start is a single pulse tied to a rising edge under its route
  property p_start_pulse;
    @(posedge aclk) disable iff (!aresetn)
      converter_start |-> $past(rise) && $past(ctl_route == VCC_ROUTE_ADC) ##1 !converter_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("converter start not a routed single pulse");

  // pin copies the result one edge late, only under its route
  property p_pin_route;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_route == VCC_ROUTE_PIN) ##1 (ctl_route == VCC_ROUTE_PIN)
        |-> comparator_output_pin == $past(comparator_pla_out);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("output pin does not follow result");

  // the falling flag only drops after a one was written to it
  property p_fall_clear;
    @(posedge aclk) disable iff (!aresetn)
      $fell(s_q.ctrl[VCC_FALL_BIT]) |-> $past(flag_clr[VCC_FALL_BIT]);
  endproperty
  a_fall_clear: assert property (p_fall_clear)
    else $error("falling flag cleared without a one written");

  // no interrupt unless the interrupt route is chosen
  property p_irq_route;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_route != VCC_ROUTE_IRQ) |-> !irq;
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("interrupt raised outside its route");

  // a reserved route code drives no destination once settled in
  property p_route_rsvd;
    @(posedge aclk) disable iff (!aresetn)
      (ctl_route == VCC_ROUTE_RSVD) ##1 (ctl_route == VCC_ROUTE_RSVD)
        |-> !comparator_output_pin && !converter_start;
  endproperty
  a_route_rsvd: assert property (p_route_rsvd)
    else $error("reserved route drove a destination");

  // reserved bits are never stored
  property p_resv_store;
    @(posedge aclk) disable iff (!aresetn)
      s_q.ctrl[VCC_REG_W-1:VCC_RESV_LO] == '0;
  endproperty
  a_resv_store: assert property (p_resv_store)
    else $error("reserved bits stored");

  // a write to an unmapped address answers with an error
  property p_wr_unmapped;
    @(posedge aclk) disable iff (!aresetn)
      commit && (s_q.aw_addr != VCC_CTRL_ADDR) && (s_q.aw_addr != VCC_MASK_ADDR)
        |=> s_axi_bvalid && (s_axi_bresp == VCC_RESP_SLVERR);
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped)
    else $error("unmapped write not answered with error");
endmodule : vcc_comparator_control

/* hdl/vcc_pkg.sv */
// constants and register layout for the voltage comparator control block
package vcc_pkg;
  // register bus geometry
  localparam int VCC_ADDR_W = 8;
  localparam int VCC_DATA_W = 32;
  localparam int VCC_REG_W = 16;
  localparam logic [VCC_ADDR_W-1:0] VCC_CTRL_ADDR = 8'h00;
  localparam logic [VCC_ADDR_W-1:0] VCC_MASK_ADDR = 8'h04;
  localparam logic [1:0] VCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VCC_RESP_SLVERR = 2'h2;

  // comparator_control field positions
  localparam int VCC_RESV_LO = 11;
  localparam int VCC_ON_BIT = 10;
  localparam int VCC_NEG_LO = 8;
  localparam int VCC_ROUTE_LO = 6;
  localparam int VCC_POL_BIT = 5;
  localparam int VCC_RESP_LO = 3;
  localparam int VCC_HYST_BIT = 2;
  localparam int VCC_RISE_BIT = 1;
  localparam int VCC_FALL_BIT = 0;
  localparam int VCC_FLAG_W = 2;

  // reset values and the bits software may write directly
  localparam logic [VCC_REG_W-1:0] VCC_CTRL_RST = 16'h0000;
  localparam logic [VCC_REG_W-1:0] VCC_CTRL_WMASK = 16'h07fc;
  localparam logic [VCC_FLAG_W-1:0] VCC_MASK_RST = 2'h0;

  // output routing codes
  typedef enum logic [1:0] {
    VCC_ROUTE_ADC = 2'b00,
    VCC_ROUTE_RSVD = 2'b01,
    VCC_ROUTE_PIN = 2'b10,
    VCC_ROUTE_IRQ = 2'b11
  } vcc_route_e;

  // negative input codes
  localparam logic [1:0] VCC_NEG_CH3 = 2'h1;
  localparam logic [1:0] VCC_NEG_DAC = 2'h2;

  // response times, in ns, and their cycle counts
  localparam int VCC_CLK_NS = 100;
  localparam int VCC_RESP0_NS = 10000;
  localparam int VCC_RESP1_NS = 5000;
  localparam int VCC_RESP2_NS = 1000;
  localparam int VCC_RESP3_NS = 500;
  localparam int VCC_CNT_W = 7;
  localparam logic [VCC_CNT_W-1:0] VCC_RESP0_CYC = VCC_CNT_W'(VCC_RESP0_NS / VCC_CLK_NS);
  localparam logic [VCC_CNT_W-1:0] VCC_RESP1_CYC = VCC_CNT_W'(VCC_RESP1_NS / VCC_CLK_NS);
  localparam logic [VCC_CNT_W-1:0] VCC_RESP2_CYC = VCC_CNT_W'(VCC_RESP2_NS / VCC_CLK_NS);
  localparam logic [VCC_CNT_W-1:0] VCC_RESP3_CYC = VCC_CNT_W'(VCC_RESP3_NS / VCC_CLK_NS);
endpackage : vcc_pkg

/* hdl/vcc_response_filter.sv */
// settling filter that models the selectable comparator response time
`timescale 1ns/1ps
module vcc_response_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw decision and speed select
  input wire logic sample,
  input wire logic [1:0] time_sel,
  // settled decision
  output logic settled_q
);
  import vcc_pkg::*;

  typedef struct packed {
    logic [VCC_CNT_W-1:0] cnt;
    logic out;
  } vcc_filt_s;

  vcc_filt_s s_q;
  vcc_filt_s s_d;

  // cycles a new level must persist before it is believed
  function automatic logic [VCC_CNT_W-1:0] vcc_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: vcc_limit = VCC_RESP0_CYC;
      2'b01: vcc_limit = VCC_RESP1_CYC;
      2'b10: vcc_limit = VCC_RESP2_CYC;
      2'b11: vcc_limit = VCC_RESP3_CYC;
    endcase
  endfunction : vcc_limit

  // a level change is taken only after it held for the whole response time
  always_comb begin
    s_d = s_q;
    if (sample == s_q.out) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + 1'b1 >= vcc_limit(time_sel)) begin
      s_d.out = sample;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign settled_q = s_q.out;
endmodule : vcc_response_filter

/* testbench/tb_voltage_comparator_control.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_voltage_comparator_control;
  import vcc_pkg::*;
  logic aclk, aresetn, awv, wv, bready, arv, rready, pos_above;
  logic awr, wr, bv, arr, rv, raw, on, pc, n3, nd, hy, pla, pin, cs, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rts, rsp;
  int mismatches, check_count;

  vcc_comparator_control uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .compare_raw(raw), .comparator_on(on), .positive_input_connect(pc),
    .negative_select_channel_three(n3), .negative_select_first_dac(nd),
    .response_time_select(rts), .hysteresis_on(hy), .comparator_pla_out(pla),
    .comparator_output_pin(pin), .converter_start(cs), .irq(irq));

  vcc_analog_model model (.aclk(aclk), .comparator_on(on), .positive_input_connect(pc),
    .negative_select_channel_three(n3), .negative_select_first_dac(nd),
    .pos_above(pos_above), .compare_raw(raw));

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // handshakes are judged mid-cycle, so the rising edge takes exactly what was seen
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do @(negedge aclk); while (!bv);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (!rv);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd_reg

  task automatic t_reset;
    rd_reg(VCC_CTRL_ADDR);
    chk("ctrl reset", rd, 32'h0000_0000);
    chk("rd okay", rsp, VCC_RESP_OKAY);
    rd_reg(VCC_MASK_ADDR);
    chk("mask reset", rd, 32'h0000_0000);
    chk("irq reset", irq, 1'b0);
    $display("done reset");
  endtask : t_reset

  task automatic t_fields;
    wr_reg(VCC_CTRL_ADDR, 32'hffff_ffff);
    chk("wr okay", rsp, VCC_RESP_OKAY);
    rd_reg(VCC_CTRL_ADDR);
    chk("ctrl ones", rd, 32'h0000_07fc);
    chk("on", on, 1'b1);
    chk("resp time", rts, 2'h3);
    chk("hyst", hy, 1'b1);
    chk("neg rsvd", {n3, nd}, 2'h0);
    wr_reg(8'h08, 32'h0000_0400);
    chk("wr unmapped", rsp, VCC_RESP_SLVERR);
    rd_reg(8'h08);
    chk("rd unmapped data", rd, 32'h0000_0000);
    chk("rd unmapped resp", rsp, VCC_RESP_SLVERR);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_0000);
    chk("off", {on, pc, hy}, 3'h0);
    $display("done fields");
  endtask : t_fields

  task automatic t_neg;
    for (int c = 1; c < 3; c++) begin
      wr_reg(VCC_CTRL_ADDR, 32'h0000_0400 | (c << 8));
      chk("neg sel", {n3, nd}, (c == 1) ? 2'h2 : 2'h1);
      chk("pos mux", pc, 1'b1);
    end
    $display("done negative input");
  endtask : t_neg

  // on, channel three, interrupt route, fastest response
  task automatic t_flags;
    wr_reg(VCC_MASK_ADDR, 32'h0000_0003);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_05d8);
    pos_above <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("pla", pla, 1'b1);
    chk("irq rise", irq, 1'b1);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_05d8);
    rd_reg(VCC_CTRL_ADDR);
    chk("rise kept", rd, 32'h0000_05da);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_05da);
    rd_reg(VCC_CTRL_ADDR);
    chk("rise clr", rd, 32'h0000_05d8);
    pos_above <= 1'b0;
    repeat (12) @(posedge aclk);
    rd_reg(VCC_CTRL_ADDR);
    chk("fall set", rd, 32'h0000_05d9);
    wr_reg(VCC_MASK_ADDR, 32'h0000_0002);
    chk("irq masked", irq, 1'b0);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_05d9);
    rd_reg(VCC_CTRL_ADDR);
    chk("fall clr", rd, 32'h0000_05d8);
    $display("done flags");
  endtask : t_flags

  task automatic t_pol;
    pos_above <= 1'b1;
    wr_reg(VCC_CTRL_ADDR, 32'h0000_05f8);
    repeat (12) @(posedge aclk);
    chk("pol above", pla, 1'b0);
    pos_above <= 1'b0;
    repeat (12) @(posedge aclk);
    chk("pol below", pla, 1'b1);
    $display("done polarity");
  endtask : t_pol

  task automatic t_route;
    int n;
    n = 0;
    wr_reg(VCC_CTRL_ADDR, 32'h0000_051b);
    repeat (12) @(posedge aclk);
    pos_above <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      @(negedge aclk);
      n += int'(cs);
    end
    chk("start pulses", n, 1);
    chk("pin idle", pin, 1'b0);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_0598);
    repeat (3) @(posedge aclk);
    chk("pin", pin, 1'b1);
    wr_reg(VCC_CTRL_ADDR, 32'h0000_0558);
    repeat (3) @(posedge aclk);
    chk("route rsvd", {pin, cs, irq}, 3'h0);
    $display("done routing");
  endtask : t_route

  initial begin
    aresetn = 1'b0;
    {awv, wv, bready, arv, rready, pos_above} = 6'h0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0000_0000;
    wstrb = 4'h3;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_fields;
    t_neg;
    t_flags;
    t_pol;
    t_route;
    end_sim;
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1_000_000;
    mismatches++;
    end_sim;
  end
endmodule : tb_voltage_comparator_control

/* testbench/vcc_analog_model.sv */
// behavioural analog comparator on the far side of the control block
`timescale 1ns/1ps
module vcc_analog_model (
  // clock
  input wire logic aclk,
  // analog controls from the block
  input wire logic comparator_on,
  input wire logic positive_input_connect,
  input wire logic negative_select_channel_three,
  input wire logic negative_select_first_dac,
  // stimulus, positive input above negative input
  input wire logic pos_above,
  // decision
  output logic compare_raw
);
  initial compare_raw = 1'b0;
  // no input path means no valid decision, so it wanders every cycle
  always @(posedge aclk) begin
    if (comparator_on && positive_input_connect &&
        (negative_select_channel_three ^ negative_select_first_dac)) begin
      compare_raw <= pos_above;
    end else begin
      compare_raw <= ~compare_raw;
    end
  end
endmodule : vcc_analog_model
